// ---- rtl/dsl_pkg.sv ----
// Package of constants for the serial load path of the converter
package dsl_pkg;
  localparam int DSL_WORD_W = 16;
  localparam int DSL_SEG_BITS = 4;
  localparam int DSL_SEG_LINES = 15;
  localparam int DSL_LADDER_W = 12;
  localparam logic [15:0] DSL_LATCH_RST = 16'h0000;
  localparam int DSL_CLK_MHZ = 100;
  localparam int DSL_PWRUP_US = 10;
  localparam int DSL_PWRUP_CYC = DSL_PWRUP_US * DSL_CLK_MHZ;
  localparam int DSL_SYNC_STAGES = 2;
endpackage

// ---- rtl/dsl_sync.sv ----
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module dsl_sync #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      meta_r <= '1;
      q <= '1;
    end
    else if (clk_en)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ---- rtl/dsl_load_path.sv ----
// Serial input, input register and latch of the 16-bit converter
// Notes on behaviour
// - Chip select high: clock and data ignored
// - Chip select low: shift data MSB first
// - Chip select rising copies shift to input
// - All three registers are sixteen bits
// - Extra clocks: last sixteen bits kept
// - Input register and latch reset to zero
// - Shift register not cleared by reset
// - Short frame keeps old shift bits
// - Without load pin, latch follows input
// - Load pin low updates latch from input
// - Load tied low updates right after
// - Load low: latch follows input continuously
// - Four MSBs to fifteen thermometer lines
// - Code is straight unsigned binary
`timescale 1ns/1ns
module dsl_load_path
  import dsl_pkg::*;
#(
  parameter bit HAS_LOAD_PIN = 1'b1,
  parameter int PWRUP_CYC = dsl_pkg::DSL_PWRUP_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Serial link pins
  input wire logic chip_sel_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_load_n,
  // Converter switch drives and latched code copy
  output logic [dsl_pkg::DSL_SEG_LINES-1:0] segment_switches,
  output logic [dsl_pkg::DSL_LADDER_W-1:0] ladder_switches,
  output logic [dsl_pkg::DSL_WORD_W-1:0] latch_code,
  // Status
  output logic link_ready,
  output logic word_loaded
);
  import dsl_pkg::*;

  // Elaboration checks; the decode and the counter rely on these sizes
  if (DSL_SEG_BITS + DSL_LADDER_W != DSL_WORD_W)
  begin : g_bad_split
    $error("segment and ladder fields must fill the word");
  end
  if (DSL_SEG_LINES != (1 << DSL_SEG_BITS) - 1)
  begin : g_bad_therm
    $error("thermometer needs one line per segment step");
  end
  if (PWRUP_CYC < 1)
  begin : g_bad_wait
    $error("power-up wait needs at least one cycle");
  end
  if (DSL_SYNC_STAGES != 2)
  begin : g_bad_sync
    $error("pin synchroniser is built with two stages");
  end
  if ($bits(DSL_LATCH_RST) != DSL_WORD_W)
  begin : g_bad_rst
    $error("latch reset value must be one word wide");
  end

  // Thermometer decode of the segment field
  // Line i is on when the code exceeds i, so lines only ever fill
  // from the bottom and no two codes share a pattern
  function automatic logic [DSL_SEG_LINES-1:0] therm(
    input logic [DSL_SEG_BITS-1:0] c);
    logic [DSL_SEG_LINES-1:0] t;
    t = '0;
    for (int i = 0; i < DSL_SEG_LINES; i++)
      t[i] = (32'(c) > i);
    return t;
  endfunction

  logic cs_s, sck_s, sdi_s, ld_s;
  logic cs_d_r, sck_d_r;
  logic [DSL_WORD_W-1:0] shift_r;
  logic [DSL_WORD_W-1:0] input_r;
  logic [DSL_WORD_W-1:0] latch_r;
  logic [$clog2(PWRUP_CYC+1)-1:0] pwr_cnt_r;
  logic sck_rise, cs_rise, load_act;
  logic pwr_done;

  // Pins pass two flops before use
  // Seen from the pins, a chip select rise reaches cs_s two cycles
  // later; the input register loads on the next edge, the latch one
  // edge after that and the switch drives one more edge later.
  // The link clock must stay at each level for more than one cycle,
  // otherwise edges are lost between samples.
  // A low enable freezes the synchroniser too, so pin activity
  // during a freeze is not seen at all.
  dsl_sync #(.W(4)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .d({chip_sel_n, ser_clk, ser_data, latch_load_n}),
    .q({cs_s, sck_s, sdi_s, ld_s})
  );

  // Chip select history; resets to the idle high level
  always_ff @(posedge mclk)
  begin
    if (reset)
      cs_d_r <= 1'b1;
    else if (clk_en)
      cs_d_r <= cs_s;
  end

  // Serial clock history; starts high so that a pin resting low
  // after reset cannot fake a rising edge
  always_ff @(posedge mclk)
  begin
    if (reset)
      sck_d_r <= 1'b1;
    else if (clk_en)
      sck_d_r <= sck_s;
  end

  // Rising link clock counts only inside a frame
  assign sck_rise = sck_s & ~sck_d_r & ~cs_s;
  // Frame end: chip select back high
  assign cs_rise = cs_s & ~cs_d_r;
  // Without a load pin the latch behaves as if it were tied low
  assign load_act = HAS_LOAD_PIN ? ~ld_s : 1'b1;

  // Shift register; no reset so old bits survive short frames
  // Older bits fall off the top, so long frames keep the last word
  always_ff @(posedge mclk)
  begin
    if (clk_en && sck_rise)
      shift_r <= {shift_r[DSL_WORD_W-2:0], sdi_s};
  end

  // Input register loads on chip select release, no bit count
  // A cut frame is loaded as it stands; the master must resend
  always_ff @(posedge mclk)
  begin
    if (reset)
      input_r <= DSL_LATCH_RST;
    else if (clk_en && cs_rise)
      input_r <= shift_r;
  end

  // Latch is level sensitive on the load input
  // While the load input is low the latch tracks the input register
  // every cycle; a load pulsed low while a frame is open would pass
  // the old word, which is why the master keeps it high then.
  always_ff @(posedge mclk)
  begin
    if (reset)
      latch_r <= DSL_LATCH_RST;
    else if (clk_en && load_act)
      latch_r <= input_r;
  end

  // Segment lines from the four top latch bits
  always_ff @(posedge mclk)
  begin
    if (reset)
      segment_switches <= '0;
    else if (clk_en)
      segment_switches <= therm(latch_r[DSL_WORD_W-1 -: DSL_SEG_BITS]);
  end

  // Ladder bits straight from the low latch field
  always_ff @(posedge mclk)
  begin
    if (reset)
      ladder_switches <= '0;
    else if (clk_en)
      ladder_switches <= latch_r[DSL_LADDER_W-1:0];
  end

  // Code copy for status; straight unsigned binary, no offset
  always_ff @(posedge mclk)
  begin
    if (reset)
      latch_code <= DSL_LATCH_RST;
    else if (clk_en)
      latch_code <= latch_r;
  end

  // Load event pulse for the surrounding logic
  always_ff @(posedge mclk)
  begin
    if (reset)
      word_loaded <= 1'b0;
    else if (clk_en)
      word_loaded <= cs_rise;
  end

  // Wait counter reaches its end after PWRUP_CYC enabled cycles
  assign pwr_done = 32'(pwr_cnt_r) >= PWRUP_CYC - 1;

  // Power-up wait indicator for the master side
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pwr_cnt_r <= '0;
      link_ready <= 1'b0;
    end
    else if (clk_en && !link_ready)
    begin
      pwr_cnt_r <= pwr_cnt_r + 1'b1;
      if (pwr_done)
        link_ready <= 1'b1;
    end
  end
endmodule

// ---- test/dsl_master.sv ----
// Serial master model for the load path bench
`timescale 1ns/1ns
module dsl_master (
  output logic chip_sel_n = 1, ser_clk = 0, ser_data = 0
);
  // Data moves with clock low; clock idles low between frames
  task send(logic [31:0] w, int n, logic cs);
    chip_sel_n = cs;
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_data = w[i];
      #40 ser_clk = 1;
      #40 ser_clk = 0;
    end
    #40 chip_sel_n = 1;
    ser_data = ~ser_data; // No stale bit once released
  endtask
endmodule

// ---- test/dsl_load_path_sva.sv ----
// Port assertions for the serial load path
`timescale 1ns/1ns
module dsl_load_path_sva (
  input wire logic mclk, reset, chip_sel_n, latch_load_n, link_ready,
  input wire logic word_loaded, clk_en,
  input wire logic [14:0] segment_switches,
  input wire logic [11:0] ladder_switches,
  input wire logic [15:0] latch_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  seg_therm_a: assert property (segment_switches ==
    15'((16'h1 << latch_code[15:12]) - 1)) else $error("seg");
  ladder_map_a: assert property (ladder_switches ==
    latch_code[11:0]) else $error("ladder");
  zero_rst_a: assert property (disable iff (0) reset |=>
    !latch_code && !word_loaded) else $error("reset");
  pulse_one_a: assert property (word_loaded |=>
    !word_loaded) else $error("pulse");
  load_cause_a: assert property (word_loaded |->
    $past(chip_sel_n, 3)) else $error("cause");
  cs_load_a: assert property (disable iff (reset || !clk_en)
    $rose(chip_sel_n) |-> ##[2:6] word_loaded) else $error("load");
  latch_hold_a: assert property (latch_load_n [*6] |=>
    $stable(latch_code)) else $error("hold");
  ready_keep_a: assert property (link_ready |=>
    link_ready) else $error("ready");
  cover property (word_loaded);
  cover property (!latch_load_n);
  cover property (&latch_code);
endmodule
bind dsl_load_path dsl_load_path_sva u_sva (.*);

// ---- test/dsl_load_path_tb.sv ----
// Bench for the serial load path
`timescale 1ns/1ns
module dsl_load_path_tb;
  logic mclk = 0, reset = 1, clk_en = 1, latch_load_n = 0;
  logic chip_sel_n, ser_clk, ser_data, link_ready, word_loaded;
  logic [14:0] segment_switches;
  logic [11:0] ladder_switches;
  logic [15:0] latch_code;
  int errors, compares, k;
  // Rows: frame bits, bit count, latch expected
  logic [55:0] rows [4] = '{56'h8000_10_8000, 56'ha1234_14_1234,
    56'h5_04_2345, 56'hffff_10_ffff};
  always #5 mclk = ~mclk;
  dsl_master m (.*);
  dsl_load_path #(.PWRUP_CYC(5)) DUT (.*);
  task chk(string s, logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Frame, bounded wait for the load pulse, then latch check
  task frame(logic [31:0] w, int n, logic cs, logic [15:0] e);
    logic [15:0] t;
    @(posedge mclk) #1 m.send(w, n, cs);
    for (k = 0; k < 20 && !cs && word_loaded !== 1'b1; k++)
      @(posedge mclk) #1;
    if (k == 20)
    begin
      errors++;
      $display("mismatch load_pulse exp 1 got 0");
      complete_run;
    end
    repeat (8) @(posedge mclk);
    t = 16'((17'h1 << e[15:12]) - 17'h1);
    chk("latch", e, latch_code);
    chk("ladder", {4'h0, e[11:0]}, {4'h0, ladder_switches});
    chk("segment", t, {1'b0, segment_switches});
    $display("frame %h done", w);
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 reset = 0;
    chk("reset", 0, latch_code);
    for (k = 0; k < 20 && link_ready !== 1'b1; k++)
      @(posedge mclk);
    chk("ready", 1, 16'(link_ready));
    foreach (rows[i])
      frame(rows[i][55:24], rows[i][23:16], 0, rows[i][15:0]);
    @(posedge mclk) #1 latch_load_n = 1;
    frame(32'h0f0f, 16, 0, 16'hffff);
    @(posedge mclk) #1 latch_load_n = 0;
    frame(32'h3c3c, 16, 1, 16'h0f0f);
    frame(0, 0, 0, 16'h0f0f);
    @(posedge mclk) #1 reset = 1;
    repeat (4) @(posedge mclk);
    #1 chk("rst_latch", 0, latch_code);
    chk("rst_ready", 0, 16'(link_ready));
    reset = 0;
    for (k = 0; k < 20 && link_ready !== 1'b1; k++)
      @(posedge mclk) #1;
    chk("ready", 1, 16'(link_ready));
    $display("reset test done");
    frame(32'h5, 4, 0, 16'hf0f5);
    @(posedge mclk) #1 clk_en = 0;
    m.send(32'h1111, 16, 0);
    repeat (4) @(posedge mclk);
    chk("freeze", 16'hf0f5, latch_code);
    $display("freeze test done");
    #1 clk_en = 1;
    complete_run;
  end
endmodule
